// [logic/clock_gen_cfg.svh]
// Offsets, field positions, reset values and counts of the clock generator control block
`ifndef CLOCK_GEN_CFG_SVH
`define CLOCK_GEN_CFG_SVH
`define OFS_CONTROL 18'h00000
`define OFS_MULTIPLIER 18'h00004
`define OFS_TRIM 18'h00008
`define OFS_DIVIDER 18'h0000c
`define OFS_STAGE 18'h00010
// Stored trim words are known by word index; their byte address is four times the index
`define IDX_STORED_HIGH 16'hff80
`define IDX_STORED_LOW 16'hff81
`define OFS_STORED_HIGH {`IDX_STORED_HIGH, 2'h0}
`define OFS_STORED_LOW {`IDX_STORED_LOW, 2'h0}
`define BIT_IRQ_ENABLE 7
`define BIT_FLAG 6
`define BIT_MON_ON 5
`define BIT_SELECT 4
`define BIT_INT_ON 3
`define BIT_INT_STABLE 2
`define BIT_EXT_ON 1
`define BIT_EXT_STABLE 0
`define RST_MULTIPLIER 7'h15
`define RST_TRIM 8'h80
`define DIVIDER_MAX 4'h9
`define EXT_COUNT_CRYSTAL 13'h1000
`define EXT_COUNT_PLAIN 13'h0010
`endif

// [logic/clock_gen_pkg.sv]
// Types shared by the clock generator control block
package clock_gen_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DATA_READ = 3'b010,
    ST_DATA_WRITE = 3'b100
  } bus_state_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// [logic/ext_stable_counter.sv]
// Counts external clock ticks after enable to mark the external generator stable
`timescale 1ns/10ps
`include "clock_gen_cfg.svh"
module ext_stable_counter
  import clock_gen_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clear,
  input wire logic ext_tick,
  input wire logic crystal_option,
  output logic stable
);
  logic [12:0] count;
  logic [12:0] target;

  // Short count for an oscillator-free source, long one for a crystal start-up
  assign target = crystal_option ? `EXT_COUNT_CRYSTAL : `EXT_COUNT_PLAIN;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 13'h0000;
      stable <= 1'b0;
    end else if (clear) begin
      count <= 13'h0000;
      stable <= 1'b0;
    end else if (!stable && ext_tick) begin
      if (count + 13'h0001 >= target) begin
        stable <= 1'b1;
      end
      count <= count + 13'h0001;
    end
  end

  property p_clear_drops;
    @(posedge hclk) disable iff (!hresetn)
    clear |=> !stable;
  endproperty
  a_clear_drops: assert property (p_clear_drops) else $error("stable survived a clear");
endmodule // ext_stable_counter

// [logic/clock_gen_control_regs.sv]
// AHB-Lite register block controlling the internal and external clock generators
//
// Implementation choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`include "clock_gen_cfg.svh"
module clock_gen_control_regs
  import clock_gen_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic internal_inactive,
  input wire logic external_inactive,
  input wire logic internal_within_target,
  input wire logic external_clock_tick,
  input wire logic stop_mode,
  input wire logic run_in_stop_option,
  input wire logic ext_clock_option,
  input wire logic crystal_option,
  input wire logic filter_update,
  input wire logic [3:0] filter_halving,
  input wire logic [7:0] filter_stage,
  input wire logic [7:0] stored_trim_high_supply,
  input wire logic [7:0] stored_trim_low_supply,
  output logic monitor_irq,
  output logic oscillator_select_external,
  output logic internal_gen_enable,
  output logic external_gen_enable,
  output logic generator_halted,
  output logic [6:0] effective_multiplier,
  output logic [7:0] trim_factor,
  output logic [3:0] effective_halving,
  output logic [7:0] stage_factor
);
  bus_state_t state;
  logic [17:0] addr_q;
  logic access;
  logic stop_off;
  logic monitor_drop;
  logic wr_ctrl, wr_mult, wr_trim, wr_div, wr_stage, rd_ctrl;
  logic [7:0] wbyte;
  logic monitor_irq_enable, monitor_flag, monitor_on, clock_select;
  logic internal_on, internal_stable, external_on, external_stable;
  logic flag_seen;
  logic [6:0] multiplier;
  logic [3:0] osc_halving_count;
  logic [7:0] osc_stage_count;
  logic ext_clear;
  reg_byte_t ctrl_view;

  assign access = hsel && hready && htrans[1];
  assign stop_off = stop_mode && !run_in_stop_option;
  // Enable and flag fall in the same edge as the monitor, so none outlives it
  assign monitor_drop = !internal_on || !external_on || stop_off;
  assign generator_halted = stop_off;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign wbyte = hwdata[7:0];

  // Address phase captured, data acted on in the following cycle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= ST_IDLE;
      addr_q <= 18'h00000;
    end else if (access) begin
      state <= hwrite ? ST_DATA_WRITE : ST_DATA_READ;
      addr_q <= haddr[17:0];
    end else begin
      state <= ST_IDLE;
    end
  end

  always_comb begin
    wr_ctrl = 1'b0;
    wr_mult = 1'b0;
    wr_trim = 1'b0;
    wr_div = 1'b0;
    wr_stage = 1'b0;
    rd_ctrl = 1'b0;
    case (state)
      ST_DATA_WRITE: begin
        wr_ctrl = (addr_q == `OFS_CONTROL);
        wr_mult = (addr_q == `OFS_MULTIPLIER);
        wr_trim = (addr_q == `OFS_TRIM);
        wr_div = (addr_q == `OFS_DIVIDER);
        wr_stage = (addr_q == `OFS_STAGE);
      end
      ST_DATA_READ: rd_ctrl = (addr_q == `OFS_CONTROL);
      ST_IDLE: rd_ctrl = 1'b0;
      default: rd_ctrl = 1'b0;
    endcase
  end

  assign ctrl_view = {monitor_irq_enable, monitor_flag, monitor_on, clock_select,
                      internal_on, internal_stable, external_on, external_stable};

  // Read data registered at the address phase; unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (access && !hwrite) begin
      case (haddr[17:0])
        `OFS_CONTROL: hrdata <= {24'h000000, ctrl_view};
        `OFS_MULTIPLIER: hrdata <= {25'h0, multiplier};
        `OFS_TRIM: hrdata <= {24'h000000, trim_factor};
        `OFS_DIVIDER: hrdata <= {28'h0000000, osc_halving_count};
        `OFS_STAGE: hrdata <= {24'h000000, osc_stage_count};
        `OFS_STORED_HIGH: hrdata <= {24'h000000, stored_trim_high_supply};
        `OFS_STORED_LOW: hrdata <= {24'h000000, stored_trim_low_supply};
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // Monitor on: forced terms tested ahead of the write so they win
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      monitor_on <= 1'b0;
    end else if (monitor_drop) begin
      monitor_on <= 1'b0;
    end else if (monitor_flag ||
                 (monitor_on && (internal_inactive || external_inactive))) begin
      // Held on at the edge the flag sets too, so a loss is discarded only when monitor_drop clears the monitor
      monitor_on <= 1'b1;
    end else if (wr_ctrl) begin
      monitor_on <= wbyte[`BIT_MON_ON] &&
                    (monitor_on || (internal_stable && external_stable));
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      monitor_irq_enable <= 1'b0;
    end else if (!monitor_on || monitor_drop) begin
      monitor_irq_enable <= 1'b0;
    end else if (wr_ctrl) begin
      monitor_irq_enable <= wbyte[`BIT_IRQ_ENABLE];
    end
  end

  assign monitor_irq = monitor_irq_enable && monitor_flag;

  // Flag: read while set arms the clear, detection wins over the clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      monitor_flag <= 1'b0;
      flag_seen <= 1'b0;
    end else if (!monitor_on || monitor_drop) begin
      monitor_flag <= 1'b0;
      flag_seen <= 1'b0;
    end else if (internal_inactive || external_inactive) begin
      monitor_flag <= 1'b1;
    end else if (wr_ctrl && flag_seen && !wbyte[`BIT_FLAG]) begin
      monitor_flag <= 1'b0;
      flag_seen <= 1'b0;
    end else if (rd_ctrl && monitor_flag) begin
      flag_seen <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clock_select <= 1'b0;
    end else if (external_inactive || !external_on) begin
      clock_select <= 1'b0;
    end else if (internal_inactive || !internal_on) begin
      clock_select <= 1'b1;
    end else if (wr_ctrl) begin
      if (wbyte[`BIT_SELECT] && external_stable) begin
        clock_select <= 1'b1;
      end else if (!wbyte[`BIT_SELECT] && internal_stable) begin
        clock_select <= 1'b0;
      end
    end
  end

  assign oscillator_select_external = clock_select;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_on <= 1'b1;
    end else if (monitor_on || !clock_select) begin
      internal_on <= 1'b1;
    end else if (wr_ctrl) begin
      internal_on <= wbyte[`BIT_INT_ON];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      external_on <= 1'b0;
    end else if (monitor_on || clock_select) begin
      external_on <= 1'b1;
    end else if (wr_ctrl) begin
      external_on <= wbyte[`BIT_EXT_ON] && ext_clock_option;
    end else if (!ext_clock_option) begin
      external_on <= 1'b0;
    end
  end

  assign internal_gen_enable = internal_on && !stop_off;
  assign external_gen_enable = external_on && !stop_off;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      internal_stable <= 1'b0;
    end else if (internal_inactive || !internal_on || stop_off ||
                 (wr_mult && !monitor_on) || (wr_trim && !monitor_on)) begin
      internal_stable <= 1'b0;
    end else begin
      internal_stable <= internal_within_target;
    end
  end

  assign ext_clear = external_inactive || !external_on || stop_off;

  ext_stable_counter u_ext_stable (
    .hclk(hclk),
    .hresetn(hresetn),
    .clear(ext_clear),
    .ext_tick(external_clock_tick),
    .crystal_option(crystal_option),
    .stable(external_stable)
  );

  // Multiplier and trim are frozen while the monitor watches the clocks
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      multiplier <= `RST_MULTIPLIER;
      trim_factor <= `RST_TRIM;
    end else begin
      if (wr_mult && !monitor_on) begin
        multiplier <= wbyte[6:0];
      end
      if (wr_trim && !monitor_on) begin
        trim_factor <= wbyte;
      end
    end
  end

  assign effective_multiplier = (multiplier == 7'h00) ? 7'h01 : multiplier;

  // No reset: the oscillator keeps running, so these hold their value
  always_ff @(posedge hclk) begin
    if (internal_on) begin
      if (filter_update) begin
        osc_halving_count <= filter_halving;
        osc_stage_count <= filter_stage;
      end
    end else begin
      if (wr_div) begin
        osc_halving_count <= wbyte[3:0];
      end
      if (wr_stage) begin
        osc_stage_count <= wbyte;
      end
    end
  end

  assign effective_halving = (osc_halving_count > `DIVIDER_MAX) ? `DIVIDER_MAX
                                                                : osc_halving_count;
  assign stage_factor = osc_stage_count;

  property p_irq;
    @(posedge hclk) disable iff (!hresetn)
    monitor_irq |-> (monitor_on && monitor_flag);
  endproperty
  a_irq: assert property (p_irq) else $error("irq mismatch");

  property p_enable_needs_mon;
    @(posedge hclk) disable iff (!hresetn)
    $rose(monitor_irq_enable) |-> $past(monitor_on);
  endproperty
  a_enable_needs_mon: assert property (p_enable_needs_mon) else $error("enable early");

  property p_flag_set;
    @(posedge hclk) disable iff (!hresetn)
    (monitor_on && internal_on && external_on && !stop_off &&
     (internal_inactive || external_inactive)) |=> monitor_flag;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");

  property p_flag_off;
    @(posedge hclk) disable iff (!hresetn)
    !monitor_on |-> !monitor_flag;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("flag without monitor");

  property p_mon_rise;
    @(posedge hclk) disable iff (!hresetn)
    $rose(monitor_on) |-> $past(internal_stable && external_stable);
  endproperty
  a_mon_rise: assert property (p_mon_rise) else $error("monitor set unstable");

  property p_mon_forced;
    @(posedge hclk) disable iff (!hresetn)
    !internal_on || !external_on |=> !monitor_on;
  endproperty
  a_mon_forced: assert property (p_mon_forced) else $error("monitor not cleared");

  property p_ext_on_forced;
    @(posedge hclk) disable iff (!hresetn)
    clock_select |=> external_on;
  endproperty
  a_ext_on_forced: assert property (p_ext_on_forced) else $error("external off");

  property p_mult_locked;
    @(posedge hclk) disable iff (!hresetn)
    monitor_on && wr_mult |=> $stable(multiplier);
  endproperty
  a_mult_locked: assert property (p_mult_locked) else $error("multiplier written");

  property p_zero_factor;
    @(posedge hclk) disable iff (!hresetn)
    multiplier == 7'h00 |-> effective_multiplier == 7'h01;
  endproperty
  a_zero_factor: assert property (p_zero_factor) else $error("zero factor");

  c_flag: cover property (@(posedge hclk) disable iff (!hresetn) monitor_irq);
  c_switch: cover property (@(posedge hclk) disable iff (!hresetn) $rose(clock_select));
  c_int_off: cover property (@(posedge hclk) disable iff (!hresetn) $fell(internal_on));
endmodule // clock_gen_control_regs

// [verification/testbench.sv]
// Self-checking bench for the clock generator control registers
`timescale 1ns/10ps
`include "clock_gen_cfg.svh"
module testbench;
  import clock_gen_pkg::*;
  logic hclk, hresetn, hsel, hwrite, internal_inactive, external_inactive;
  logic internal_within_target, external_clock_tick, stop_mode, run_in_stop_option;
  logic ext_clock_option, crystal_option, filter_update;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [1:0] htrans;
  logic [3:0] filter_halving, effective_halving;
  logic [7:0] filter_stage, stored_hi, stored_lo, trim_factor, stage_factor, tv, st;
  logic [6:0] effective_multiplier, mv;
  logic hreadyout, hresp, monitor_irq, osc_sel, int_en, ext_en, halted;
  int mismatches, n_compared, cycles, seed;
  clock_gen_control_regs DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .internal_inactive(internal_inactive), .external_inactive(external_inactive),
    .internal_within_target(internal_within_target), .external_clock_tick(external_clock_tick),
    .stop_mode(stop_mode), .run_in_stop_option(run_in_stop_option),
    .ext_clock_option(ext_clock_option), .crystal_option(crystal_option),
    .filter_update(filter_update), .filter_halving(filter_halving), .filter_stage(filter_stage),
    .stored_trim_high_supply(stored_hi), .stored_trim_low_supply(stored_lo),
    .monitor_irq(monitor_irq), .oscillator_select_external(osc_sel),
    .internal_gen_enable(int_en), .external_gen_enable(ext_en), .generator_halted(halted),
    .effective_multiplier(effective_multiplier), .trim_factor(trim_factor),
    .effective_halving(effective_halving), .stage_factor(stage_factor));
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  function automatic logic [6:0] exp_mul(input logic [6:0] v);
    return (v == 7'h00) ? 7'h01 : v;
  endfunction
  function automatic logic [3:0] exp_div(input logic [3:0] h);
    return (h > `DIVIDER_MAX) ? `DIVIDER_MAX : h;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Master holds each phase until hready is seen high; read data taken at data-phase edge
  task automatic xfer(input logic wr, input logic [17:0] a, input logic [31:0] wd,
      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {14'h0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task automatic wr(input logic [17:0] a, input logic [7:0] d);
    logic [31:0] x;
    xfer(1'b1, a, {24'h000000, d}, x);
  endtask
  task automatic rc(input logic [17:0] a, input logic [7:0] e);
    logic [31:0] x;
    xfer(1'b0, a, 32'h00000000, x);
    chk(x, {24'h000000, e});
  endtask
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge hclk);
      external_clock_tick <= 1'b1;
      @(posedge hclk);
      external_clock_tick <= 1'b0;
    end
  endtask
  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      wrap_up();
    end
  end
  initial begin
    seed = 4157;
    hresetn = 1'b0;
    {hsel, hwrite, internal_inactive, external_inactive, internal_within_target} = '0;
    {external_clock_tick, stop_mode, run_in_stop_option, ext_clock_option} = '0;
    {crystal_option, filter_update} = '0;
    haddr = '0;
    hwdata = '0;
    htrans = 2'b00;
    filter_halving = 4'h0;
    filter_stage = 8'h00;
    stored_hi = 8'($random(seed));
    stored_lo = 8'($random(seed));
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rc(`OFS_CONTROL, 8'h08);
    rc(`OFS_MULTIPLIER, 8'h15);
    rc(`OFS_TRIM, 8'h80);
    rc(`OFS_STORED_HIGH, stored_hi);
    rc(`OFS_STORED_LOW, stored_lo);
    xfer(1'b0, 18'h00200, 32'h0, r);
    chk(r, 32'h0);
    chk({31'h0, hresp}, 32'h0);
    // Status bits and an early interrupt enable must both be refused
    wr(`OFS_CONTROL, 8'hc5);
    rc(`OFS_CONTROL, 8'h08);
    for (int i = 0; i < 8; i++) begin
      mv = (i == 0) ? 7'h00 : 7'($random(seed));
      tv = (i == 0) ? 8'hff : 8'($random(seed));
      wr(`OFS_MULTIPLIER, {1'b0, mv});
      wr(`OFS_TRIM, tv);
      rc(`OFS_MULTIPLIER, {1'b0, mv});
      chk({25'h0, effective_multiplier}, {25'h0, exp_mul(mv)});
      chk({24'h0, trim_factor}, {24'h0, tv});
    end
    wr(`OFS_CONTROL, 8'h0a);
    rc(`OFS_CONTROL, 8'h08);
    ext_clock_option <= 1'b1;
    wr(`OFS_CONTROL, 8'h0a);
    rc(`OFS_CONTROL, 8'h0a);
    chk({31'h0, ext_en}, 32'h1);
    ticks(15);
    rc(`OFS_CONTROL, 8'h0a);
    ticks(1);
    rc(`OFS_CONTROL, 8'h0b);
    internal_within_target <= 1'b1;
    rc(`OFS_CONTROL, 8'h0f);
    wr(`OFS_CONTROL, 8'h1f);
    rc(`OFS_CONTROL, 8'h1f);
    chk({31'h0, osc_sel}, 32'h1);
    wr(`OFS_CONTROL, 8'h3f);
    rc(`OFS_CONTROL, 8'h3f);
    wr(`OFS_MULTIPLIER, 8'h33);
    wr(`OFS_TRIM, ~tv);
    rc(`OFS_MULTIPLIER, {1'b0, mv});
    rc(`OFS_TRIM, tv);
    wr(`OFS_CONTROL, 8'hbf);
    rc(`OFS_CONTROL, 8'hbf);
    // Generators may not be turned off beneath a running monitor
    wr(`OFS_CONTROL, 8'hb5);
    rc(`OFS_CONTROL, 8'hbf);
    external_inactive <= 1'b1;
    repeat (3) @(posedge hclk);
    external_inactive <= 1'b0;
    rc(`OFS_CONTROL, 8'hee);
    chk({31'h0, monitor_irq}, 32'h1);
    wr(`OFS_CONTROL, 8'hae);
    rc(`OFS_CONTROL, 8'hae);
    chk({31'h0, monitor_irq}, 32'h0);
    stop_mode <= 1'b1;
    rc(`OFS_CONTROL, 8'h0a);
    chk({30'h0, halted, int_en}, 32'h2);
    stop_mode <= 1'b0;
    for (int h = 0; h < 16; h++) begin
      st = 8'($random(seed));
      @(posedge hclk);
      filter_halving <= 4'(h);
      filter_stage <= st;
      filter_update <= 1'b1;
      @(posedge hclk);
      filter_update <= 1'b0;
      @(posedge hclk);
      chk({28'h0, effective_halving}, {28'h0, exp_div(4'(h))});
    end
    wr(`OFS_STAGE, ~st);
    rc(`OFS_STAGE, st);
    chk({24'h0, stage_factor}, {24'h0, st});
    // Hand the output to the external clock, then switch the internal one off
    ticks(16);
    rc(`OFS_CONTROL, 8'h0f);
    repeat (2) wr(`OFS_CONTROL, 8'h12);
    rc(`OFS_CONTROL, 8'h13);
    chk({31'h0, int_en}, 32'h0);
    wr(`OFS_DIVIDER, 8'h0c);
    rc(`OFS_DIVIDER, 8'h0c);
    chk({28'h0, effective_halving}, {28'h0, exp_div(4'hc)});
    wr(`OFS_STAGE, ~st);
    rc(`OFS_STAGE, ~st);
    chk({24'h0, stage_factor}, {24'h0, ~st});
    wrap_up();
  end
endmodule // testbench
